// file: design/ssrp_top.sv
// Streaming slave read port: flow-control flags, read data and packet end marker.
// What this block does
// - Port counts as streaming because it drives the flow and packet flags.
// - Write space flag is high only while a write can be accepted.
// - Read data flag is high only while a word is available to read.
// - Read strobe, byte lanes and read word follow normal slave read timing.
// - Reads may carry setup cycles and slave-requested wait states.
// - Drop read data flag when data runs out, before the next edge.
// - Slave may raise packet end during any transfer; fabric passes it on.
// - Packet end does not stop the stream; its meaning is design-defined.
// - Packet end is presented in the same cycle as its read word.
// - Packet end may clear per transfer or be held until i_eop_clear or reset.
// - Packet end is independent of the read data flag.
// - Each completed read transfer (wait request low) with select and read strobe held yields a fresh word unless the store is empty.
`timescale 1ns/1ps
module ssrp_top
    import ssrp_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rstn,
    input  wire ssrp_req_type      i_req,
    input  wire logic              i_push_valid,
    input  wire ssrp_item_type     i_push_item,
    input  wire logic [WAIT_W-1:0] i_wait_cfg,
    input  wire logic              i_eop_hold,
    input  wire logic              i_eop_clear,
    output logic                   o_push_ready,
    output ssrp_rsp_type           o_rsp,
    output logic [DATA_W-1:0]      o_write_word,
    output logic                   o_write_valid
);

    ////////////////////////////////////////////////////////////////////////////////
    // Word store and pointers.

    ssrp_item_type      mem_r [DEPTH];
    ssrp_item_type      mem_nxt [DEPTH];
    logic [PTR_W-1:0]   wr_ptr_r;
    logic [PTR_W-1:0]   wr_ptr_nxt;
    logic [PTR_W-1:0]   rd_ptr_r;
    logic [PTR_W-1:0]   rd_ptr_nxt;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   cnt_nxt;
    ssrp_state_type     state_r;
    ssrp_state_type     state_nxt;
    ssrp_rsp_type       rsp_r;
    ssrp_rsp_type       rsp_nxt;
    logic               push_ready_r;
    logic               push_ready_nxt;
    logic [DATA_W-1:0]  wword_r;
    logic [DATA_W-1:0]  wword_nxt;
    logic               wvalid_r;
    logic               wvalid_nxt;
    logic               eop_sticky_r;
    logic               eop_sticky_nxt;
    logic               wait_start;
    logic               wait_done;
    logic               rd_active;
    logic               wr_active;
    logic               pop;
    logic               push;

    // Byte lanes disabled by an active-low mask read as zero.
    function automatic logic [DATA_W-1:0] lane_mask(input logic [DATA_W-1:0] w, input logic [BE_W-1:0] be_n);
        logic [DATA_W-1:0] r;
        r = DATA_RST;
        for (int b = 0; b < BE_W; b++) begin
            r[b*8 +: 8] = be_n[b] ? 8'h00 : w[b*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return p + PTR_ONE;
    endfunction

    // ungated access
    // Any master's read is served the same way; gating of streaming masters is the fabric's job.
    assign rd_active = i_req.select_strobe && !i_req.read_strobe_n;
    assign wr_active = i_req.select_strobe && !i_req.write_strobe_n;

    ssrp_wait_gen u_wait (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_start   (wait_start),
        .i_waits   (i_wait_cfg),
        .o_done    (wait_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read transfer sequencer.

    always_comb begin
        state_nxt  = state_r;
        wait_start = 1'b0;
        pop        = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (rd_active) begin
                    wait_start = 1'b1;
                    state_nxt  = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!rd_active) begin
                    state_nxt = ST_IDLE;
                end else if (wait_done) begin
                    state_nxt = ST_SERVE;
                end
            end
            ST_SERVE: begin
                // fresh word
                // The word is consumed, unless the store is empty, on the edge that ends the transfer, when the wait request goes high again.
                pop = (cnt_r != CNT_RST);
                if (rd_active) begin
                    wait_start = 1'b1;
                    state_nxt  = ST_WAIT;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Store, flags and answer.

    // Back-pressure on the producer keeps the store from overflowing.
    assign push = i_push_valid && push_ready_r;

    always_comb begin
        mem_nxt        = mem_r;
        wr_ptr_nxt     = wr_ptr_r;
        rd_ptr_nxt     = rd_ptr_r;
        cnt_nxt        = cnt_r;
        rsp_nxt        = rsp_r;
        eop_sticky_nxt = eop_sticky_r;
        wword_nxt      = wword_r;
        wvalid_nxt     = 1'b0;
        if (push) begin
            mem_nxt[wr_ptr_r] = i_push_item;
            wr_ptr_nxt        = ptr_inc(wr_ptr_r);
        end
        if (pop) begin
            rd_ptr_nxt = ptr_inc(rd_ptr_r);
        end
        cnt_nxt = CNT_W'(cnt_r + CNT_W'(push) - CNT_W'(pop));
        // normal read timing
        // Word is driven with the wait request low, as for a plain slave read.
        rsp_nxt.wait_request = !(state_nxt == ST_SERVE);
        if (state_nxt == ST_SERVE) begin
            rsp_nxt.read_word = lane_mask(mem_r[rd_ptr_nxt].word, i_req.byte_lane_mask_n);
        end
        // drop when empty
        // A registered flag lags one cycle, so it looks ahead at the next count.
        rsp_nxt.read_data_ready   = (cnt_nxt != CNT_RST) && !(state_nxt == ST_SERVE && cnt_nxt == CNT_W'(1));
        rsp_nxt.write_space_ready = 1'b1;
        if (i_eop_clear) begin
            eop_sticky_nxt = 1'b0;
        end
        if (state_nxt == ST_SERVE && mem_r[rd_ptr_nxt].last && i_eop_hold) begin
            eop_sticky_nxt = 1'b1;
        end
        rsp_nxt.packet_end_flag = eop_sticky_nxt || (state_nxt == ST_SERVE && mem_r[rd_ptr_nxt].last);
        if (wr_active) begin
            wword_nxt  = i_req.write_word;
            wvalid_nxt = 1'b1;
        end
        // The lookahead count already includes this edge's push, so room is simply count below depth.
        push_ready_nxt = (cnt_nxt < CNT_FULL);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wr_ptr_r     <= PTR_RST;
            rd_ptr_r     <= PTR_RST;
            cnt_r        <= CNT_RST;
            state_r      <= ST_IDLE;
            rsp_r        <= '{read_word: DATA_RST, wait_request: 1'b1, default: 1'b0};
            eop_sticky_r <= 1'b0;
            push_ready_r <= 1'b0;
            wword_r      <= DATA_RST;
            wvalid_r     <= 1'b0;
        end else begin
            mem_r        <= mem_nxt;
            wr_ptr_r     <= wr_ptr_nxt;
            rd_ptr_r     <= rd_ptr_nxt;
            cnt_r        <= cnt_nxt;
            state_r      <= state_nxt;
            rsp_r        <= rsp_nxt;
            eop_sticky_r <= eop_sticky_nxt;
            push_ready_r <= push_ready_nxt;
            wword_r      <= wword_nxt;
            wvalid_r     <= wvalid_nxt;
        end
    end

    assign o_rsp         = rsp_r;
    assign o_push_ready  = push_ready_r;
    assign o_write_word  = wword_r;
    assign o_write_valid = wvalid_r;

endmodule

// file: design/ssrp_pkg.sv
// Package for the streaming slave read port: widths, counts, reset values and carrier types.
package ssrp_pkg;

    localparam int DATA_W        = 32;
    localparam int ADDR_W        = 4;
    localparam int BE_W          = DATA_W / 8;
    localparam int DEPTH         = 8;
    localparam int PTR_W         = 3;
    localparam int CNT_W         = 4;
    localparam int WAIT_W        = 2;

    localparam logic [CNT_W-1:0]  CNT_RST      = 4'h0;
    localparam logic [CNT_W-1:0]  CNT_FULL     = 4'h8;
    localparam logic [PTR_W-1:0]  PTR_RST      = 3'h0;
    localparam logic [PTR_W-1:0]  PTR_ONE      = 3'h1;
    localparam logic [WAIT_W-1:0] WAIT_RST     = 2'h0;
    localparam logic [WAIT_W-1:0] WAIT_ONE     = 2'h1;
    localparam logic [DATA_W-1:0] DATA_RST     = 32'h0000_0000;
    localparam logic [BE_W-1:0]   BE_RST       = 4'h0;

    // Bus request from the fabric toward this slave (strobes are active low where named so).
    typedef struct packed {
        logic              select_strobe;
        logic              read_strobe_n;
        logic              write_strobe_n;
        logic [ADDR_W-1:0] address;
        logic [BE_W-1:0]   byte_lane_mask_n;
        logic [DATA_W-1:0] write_word;
    } ssrp_req_type;

    // Answer from this slave toward the fabric.
    typedef struct packed {
        logic [DATA_W-1:0] read_word;
        logic              wait_request;
        logic              read_data_ready;
        logic              write_space_ready;
        logic              packet_end_flag;
    } ssrp_rsp_type;

    // One stored word from the producer side, with its packet end marker.
    typedef struct packed {
        logic [DATA_W-1:0] word;
        logic              last;
    } ssrp_item_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_SERVE = 2'b11
    } ssrp_state_type;

endpackage

// file: design/ssrp_wait_gen.sv
// Per-word wait-state counter used by the streaming slave read port.
`timescale 1ns/1ps
module ssrp_wait_gen
    import ssrp_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rstn,
    input  wire logic              i_start,
    input  wire logic [WAIT_W-1:0] i_waits,
    output logic                   o_done
);

    logic [WAIT_W-1:0] cnt_r;
    logic [WAIT_W-1:0] cnt_nxt;
    logic              done_r;
    logic              done_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        if (i_start) begin
            cnt_nxt  = i_waits;
            done_nxt = (i_waits == WAIT_RST);
        end else if (cnt_r != WAIT_RST) begin
            cnt_nxt  = cnt_r - WAIT_ONE;
            done_nxt = (cnt_r == WAIT_ONE);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            cnt_r  <= WAIT_RST;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_done = done_r;

endmodule

// file: testbench/ssrp_top_chk.sv
// Port-level checks for the streaming slave read port.
`timescale 1ns/1ps
module ssrp_top_chk
    import ssrp_pkg::*;
(
    input wire logic              i_clk_sys,
    input wire logic              i_rstn,
    input wire ssrp_req_type      i_req,
    input wire logic              i_push_valid,
    input wire logic [WAIT_W-1:0] i_wait_cfg,
    input wire logic              i_eop_hold,
    input wire logic              i_eop_clear,
    input wire logic              o_push_ready,
    input wire ssrp_rsp_type      o_rsp
);
    logic       rd;
    logic       done;
    logic [4:0] occ_r;
    logic [4:0] occ_nxt;
    logic [2:0] wcnt_r;
    logic [2:0] wcnt_nxt;
    logic       frst_r;
    logic       frst_nxt;
    ////////////////////////////////////////
    // A shadow fill count, so the flags are judged against what was really pushed and read.
    assign rd   = i_req.select_strobe && !i_req.read_strobe_n;
    assign done = rd && !o_rsp.wait_request;
    always_comb begin
        occ_nxt  = occ_r + {4'h0, i_push_valid && o_push_ready} - {4'h0, done};
        wcnt_nxt = (rd && !done) ? wcnt_r + 3'h1 : 3'h0;
        frst_nxt = !rd || (frst_r && !done);
    end
    always_ff @(posedge i_clk_sys) begin
        occ_r  <= i_rstn ? occ_nxt : 5'h00;
        wcnt_r <= i_rstn ? wcnt_nxt : 3'h0;
        frst_r <= i_rstn ? frst_nxt : 1'b1;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    a_reset_clear: assert property (disable iff (1'b0) !i_rstn |=> o_rsp.wait_request &&
        !o_rsp.read_data_ready && !o_rsp.write_space_ready && !o_rsp.packet_end_flag) else $error("reset flags");
    a_space_ready: assert property ($past(i_rstn) |-> o_rsp.write_space_ready) else $error("write space");
    a_wait_count: assert property (done && frst_r |-> wcnt_r == {1'b0, i_wait_cfg} + 3'h2)
        else $error("wait states");
    a_data_claim: assert property (o_rsp.read_data_ready |-> occ_r != 5'h00) else $error("data claim");
    a_empty_drop: assert property (done && occ_r == 5'h01 && !(i_push_valid && o_push_ready) |=>
        !o_rsp.read_data_ready) else $error("empty flag");
    a_word_single: assert property (!o_rsp.wait_request |=> o_rsp.wait_request) else $error("word twice");
    a_end_with_word: assert property (o_rsp.packet_end_flag && !i_eop_hold |-> !o_rsp.wait_request)
        else $error("end marker");
    a_end_held: assert property (i_eop_hold && !i_eop_clear && o_rsp.packet_end_flag |=>
        o_rsp.packet_end_flag) else $error("end not held");
endmodule
bind ssrp_top ssrp_top_chk u_chk (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(i_req),
    .i_push_valid(i_push_valid), .i_wait_cfg(i_wait_cfg), .i_eop_hold(i_eop_hold),
    .i_eop_clear(i_eop_clear), .o_push_ready(o_push_ready), .o_rsp(o_rsp));

// file: testbench/ssrp_fabric_model.sv
// Behavioural bus fabric serving a streaming master in front of the slave.
`timescale 1ns/1ps
module ssrp_fabric_model
    import ssrp_pkg::*;
(
    input  wire logic         i_clk_sys,
    input  wire logic         i_rstn,
    input  wire ssrp_rsp_type i_rsp,
    input  wire logic         i_want,
    input  wire logic         i_wr,
    output ssrp_req_type      o_req,
    output logic              o_got,
    output logic [DATA_W-1:0] o_word,
    output logic              o_eop
);
    ssrp_req_type r = '{1'b0, 1'b1, 1'b1, 4'h0, 4'hf, 32'h0};
    assign o_req = r;
    ////////////////////////////////////////
    always @(posedge i_clk_sys) begin
        o_got <= 1'b0;
        if (!i_rstn || !r.write_strobe_n) begin
            r <= '{1'b0, 1'b1, 1'b1, ~r.address, ~r.byte_lane_mask_n, ~r.write_word};
        end else if (r.select_strobe) begin
            if (!i_rsp.wait_request) begin
                o_got <= 1'b1;
                o_word <= i_rsp.read_word;
                o_eop <= i_rsp.packet_end_flag;
                if (!(i_want && i_rsp.read_data_ready)) begin
                    r <= '{1'b0, 1'b1, 1'b1, ~r.address, ~r.byte_lane_mask_n, ~r.write_word};
                end
            end
        end else if (i_want && i_rsp.read_data_ready) begin
            r <= '{1'b1, 1'b0, 1'b1, 4'h0, 4'h0, ~r.write_word};
        // plain write, not gated by the read flag.
        end else if (i_wr && i_rsp.write_space_ready) begin
            r <= '{1'b1, 1'b1, 1'b0, 4'h1, 4'h0, 32'h5a5a_0f0f};
        end
    end
endmodule

// file: testbench/test_streaming_slave_read_port.sv
// Bench for the streaming slave read port: producer, fabric model, scoreboard, verdict.
`timescale 1ns/1ps
module test_streaming_slave_read_port;
    import ssrp_pkg::*;
    typedef struct {logic [1:0] cfg; int n; logic rdr;} ssrp_row_type;
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              push_valid = 1'b0;
    ssrp_item_type     push_item = '0;
    logic [WAIT_W-1:0] wait_cfg = WAIT_RST;
    logic              eop_hold = 1'b0;
    logic              eop_clear = 1'b0;
    logic              want = 1'b0;
    logic              wr = 1'b0;
    logic              push_ready, got, geop, wvalid;
    logic [DATA_W-1:0] gword, wword;
    ssrp_req_type      req;
    ssrp_rsp_type      rsp;
    ssrp_item_type     exp_q[$];
    int                fail_count = 0;
    int                tests_run = 0;
    ssrp_row_type      rows[4] = '{'{2'h0, 1, 1'b0}, '{2'h1, 2, 1'b0}, '{2'h2, 3, 1'b0}, '{2'h3, 5, 1'b0}};
    wire [3:0]         flags = {rsp.wait_request, rsp.read_data_ready, rsp.write_space_ready, rsp.packet_end_flag};
    always #10 clk = ~clk;
    ssrp_top i_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_req(req), .i_push_valid(push_valid), .i_push_item(push_item),
        .i_wait_cfg(wait_cfg), .i_eop_hold(eop_hold), .i_eop_clear(eop_clear), .o_push_ready(push_ready),
        .o_rsp(rsp), .o_write_word(wword), .o_write_valid(wvalid));
    ssrp_fabric_model i_fab (.i_clk_sys(clk), .i_rstn(rstn), .i_rsp(rsp), .i_want(want), .i_wr(wr),
        .o_req(req), .o_got(got), .o_word(gword), .o_eop(geop));
    ////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
        tests_run++;
        if (act !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, act);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic push(input logic [31:0] w, input logic l);
        int k;
        k = 0;
        push_valid <= 1'b1;
        push_item <= '{w, l};
        exp_q.push_back('{w, l});
        @(posedge clk);
        while (push_ready !== 1'b1 && k < 100) begin
            k++;
            @(posedge clk);
        end
    endtask
    task automatic wait_left(input int n);
        for (int k = 0; k < 400 && exp_q.size() > n; k++) @(posedge clk);
        chk("words left", 32'(n), 32'(exp_q.size()));
    endtask
    always @(posedge clk) begin
        if (got && exp_q.size() > 0) begin
            chk("read word", exp_q[0].word, gword);
            if (!eop_hold) chk("end marker", {31'h0, exp_q[0].last}, {31'h0, geop});
            void'(exp_q.pop_front());
        end
    end
    initial begin
        #400000;
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge clk);
        chk("reset flags", 32'h8, {28'h0, flags});
        rstn <= 1'b1;
        want <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (rows[i]) begin
            wait_cfg <= rows[i].cfg;
            for (int j = 0; j < rows[i].n; j++) push(32'h100 * i + j, j == rows[i].n - 1);
            push_valid <= 1'b0;
            wait_left(0);
            chk("ready at end", {31'h0, rows[i].rdr}, {31'h0, flags[2]});
        end
        want <= 1'b0;
        for (int j = 0; j < DEPTH; j++) push(32'ha00 + j, 1'b0);
        push_valid <= 1'b0;
        repeat (2) @(posedge clk);
        chk("store full", 32'h0, {31'h0, push_ready});
        want <= 1'b1;
        wait_left(DEPTH - 2);
        want <= 1'b0;
        repeat (20) @(posedge clk);
        chk("ready kept", 32'h1, {31'h0, flags[2]});
        want <= 1'b1;
        wait_left(0);
        chk("ready dropped", 32'h0, {31'h0, flags[2]});
        eop_hold <= 1'b1;
        push(32'he01, 1'b1);
        push(32'he02, 1'b0);
        push_valid <= 1'b0;
        wait_left(0);
        chk("end held", 32'h1, {31'h0, flags[0]});
        eop_clear <= 1'b1;
        @(posedge clk);
        eop_clear <= 1'b0;
        @(posedge clk);
        chk("end cleared", 32'h0, {31'h0, flags[0]});
        eop_hold <= 1'b0;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        for (int k = 0; k < 10 && wvalid !== 1'b1; k++) @(posedge clk);
        chk("write word", 32'h5a5a_0f0f, wword);
        stop_test;
    end
endmodule
